// ### rf_packet_address_filter.sv
/*
 Packet address filter of a hopping packet radio: classifies outgoing
 headers as global or local, filters incoming headers on channel, vendor
 number and destination, buffers admitted payload for the host and tracks
 the cold start sync window.
 Assumes an Avalon-MM master with waitrequest, header and payload streams
 from the radio front end, all synchronous to clk_sys.
*/
`include "rf_filter_defs.svh"
module rf_packet_address_filter
	import rf_filter_pkg::*;
#(
	parameter int HOP_W = `HOP_W,
	parameter int VENDOR_W = `VENDOR_W,
	parameter int FIFO_DEPTH = `FIFO_DEPTH,
	parameter int CNT_W = `BOOT_CNT_W,
	parameter logic [CNT_W-1:0] SYNC_CYCLES = CNT_W'(`SYNC_CYCLES),
	parameter logic [CNT_W-1:0] COLD_CYCLES = CNT_W'(`COLD_CYCLES)
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic rx_hdr_valid,
	output logic rx_hdr_ready,
	input wire logic [HOP_W-1:0] rx_hdr_hop,
	input wire logic [VENDOR_W-1:0] rx_hdr_vendor,
	input wire logic [15:0] rx_hdr_dest,
	input wire logic rx_hdr_global,
	input wire logic rx_hdr_ack_req,
	input wire logic rx_data_valid,
	output logic rx_data_ready,
	input wire logic [7:0] rx_data,
	input wire logic rx_data_last,
	output logic ack_send,
	output logic tx_hdr_valid,
	output logic [HOP_W-1:0] tx_hdr_hop,
	output logic [VENDOR_W-1:0] tx_hdr_vendor,
	output logic [15:0] tx_hdr_dest,
	output logic tx_hdr_global,
	output logic tx_hdr_ack_req,
	output logic synced,
	output logic tx_enabled
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Compare two addresses through a mask
	function automatic logic masked_eq(input logic [15:0] a, input logic [15:0] b,
		input logic [15:0] m);
		masked_eq = ((a & m) == (b & m));
	endfunction

	// Merge a write into a 16-bit register by byte lanes
	function automatic logic [15:0] be16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0])
		begin
			r[7:0] = wd[7:0];
		end
		if (be[1])
		begin
			r[15:8] = wd[15:8];
		end
		be16 = r;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic ack_en; // Acknowledged mode enable
		logic [15:0] src; // Own source address
		logic [15:0] mask; // Own address mask
		logic [15:0] dest; // Destination for sent packets
		logic [HOP_W-1:0] hop; // Hopping channel
		logic [VENDOR_W-1:0] vendor; // Vendor number
		rx_state_e rx_state; // Receive packet state
		logic rx_global; // Current packet is global
		logic [CNT_W-1:0] boot_cnt; // Cycles since cold start
		logic synced; // Joined peers
		logic tx_en; // Transmit allowed
		logic resp; // Bus answer cycle
		logic [31:0] rdata; // Bus read data
		logic [7:0] drop_cnt; // Packets discarded
		logic [7:0] pass_cnt; // Packets admitted
		logic tx_valid; // Header pulse
		logic [15:0] tx_dest; // Sent destination
		logic tx_global; // Sent packet is global
		logic tx_ack_req; // Sent packet wants an ack
		logic ack_send; // Ack pulse
	} filt_state_s;

	filt_state_s state_ff;
	filt_state_s nxt_state;

	logic bus_req; // Read or write pending
	logic bus_done; // Transfer completes at this edge
	logic hdr_take; // Header accepted this cycle
	logic hop_ok; // Channel matches
	logic vendor_ok; // Vendor number matches
	logic hdr_global; // Incoming packet is global
	logic local_ok; // Local address match
	logic hdr_pass; // All filters pass
	logic fifo_push; // Payload byte into buffer
	logic fifo_in_ready; // Buffer has room
	logic fifo_out_valid; // Buffer holds a byte
	logic fifo_pop; // Host takes a byte
	logic [8:0] fifo_out_data; // Head byte with last flag
	logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level; // Bytes held
	logic fifo_empty; // Nothing buffered
	logic fifo_full; // No room left

	// ----------------------------------------------------------------
	// Receive filter decode
	// ----------------------------------------------------------------
	assign rx_hdr_ready = ce && (state_ff.rx_state == RX_IDLE);
	assign hdr_take = rx_hdr_valid && rx_hdr_ready;
	assign hop_ok = (rx_hdr_hop == state_ff.hop);
	assign vendor_ok = (rx_hdr_vendor == state_ff.vendor);
	// An all-ones destination is global whatever the flag says
	assign hdr_global = rx_hdr_global || (rx_hdr_dest == `ADDR_GLOBAL);
	// Packet destination and own source both pass through our mask
	assign local_ok = masked_eq(rx_hdr_dest, state_ff.src, state_ff.mask);
	assign hdr_pass = hop_ok && vendor_ok && (hdr_global || local_ok);

	// Payload ready: buffer room when admitted, the clock enable when dropping
	always_comb
	begin
		rx_data_ready = 1'b0;
		unique case (state_ff.rx_state)
			RX_PASS: rx_data_ready = fifo_in_ready;
			RX_DROP: rx_data_ready = ce;
			default: rx_data_ready = 1'b0;
		endcase
	end

	// Only an admitted packet reaches the buffer
	assign fifo_push = (state_ff.rx_state == RX_PASS) && rx_data_valid;

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	// One wait cycle per transfer; a frozen clock enable holds the wait
	assign bus_req = avs_read || avs_write;
	assign bus_done = bus_req && state_ff.resp && ce;
	assign avs_waitrequest = bus_req && !(state_ff.resp && ce);
	assign fifo_pop = bus_done && avs_read && (avs_address == `REG_RXDATA);
	assign fifo_empty = !fifo_out_valid;
	assign fifo_full = (fifo_level == ($clog2(FIFO_DEPTH+1))'(FIFO_DEPTH));

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.tx_valid = 1'b0;
		nxt_state.ack_send = 1'b0;

		// Cold start timer stops at COLD_CYCLES, one cycle before transmit is allowed
		if (state_ff.boot_cnt < COLD_CYCLES)
		begin
			nxt_state.boot_cnt = state_ff.boot_cnt + 1'b1;
		end
		// Sync by a peer header or at the latest by the sync window
		if (state_ff.boot_cnt >= SYNC_CYCLES)
		begin
			nxt_state.synced = 1'b1;
		end
		if (hdr_take && hop_ok && vendor_ok)
		begin
			nxt_state.synced = 1'b1;
		end
		nxt_state.tx_en = (state_ff.boot_cnt >= COLD_CYCLES);

		// Receive packet sequencing
		unique case (state_ff.rx_state)
			RX_IDLE:
			begin
				if (hdr_take && hdr_pass)
				begin
					nxt_state.rx_state = RX_PASS;
					nxt_state.rx_global = hdr_global;
					nxt_state.pass_cnt = state_ff.pass_cnt + 1'b1;
					// Acks only for local packets that ask for one
					nxt_state.ack_send = !hdr_global && rx_hdr_ack_req && state_ff.ack_en;
				end
				else if (hdr_take)
				begin
					nxt_state.rx_state = RX_DROP;
					nxt_state.drop_cnt = state_ff.drop_cnt + 1'b1;
				end
			end
			RX_PASS:
			begin
				// Leave on the last byte the buffer takes
				if (fifo_push && fifo_in_ready && rx_data_last)
				begin
					nxt_state.rx_state = RX_IDLE;
				end
			end
			RX_DROP:
			begin
				// Swallow payload up to the last byte
				if (rx_data_valid && rx_data_last)
				begin
					nxt_state.rx_state = RX_IDLE;
				end
			end
			default:
			begin
				nxt_state.rx_state = RX_IDLE;
			end
		endcase

		// Bus: first cycle captures read data, second completes
		if (bus_req && !state_ff.resp)
		begin
			nxt_state.resp = 1'b1;
			nxt_state.rdata = 32'h0000_0000;
			unique case (avs_address)
				`REG_CTRL: nxt_state.rdata[`CTRL_ACK_EN] = state_ff.ack_en;
				`REG_SOURCE: nxt_state.rdata[15:0] = state_ff.src;
				`REG_MASK: nxt_state.rdata[15:0] = state_ff.mask;
				`REG_DEST: nxt_state.rdata[15:0] = state_ff.dest;
				`REG_HOP: nxt_state.rdata[HOP_W-1:0] = state_ff.hop;
				`REG_VENDOR: nxt_state.rdata[VENDOR_W-1:0] = state_ff.vendor;
				`REG_STATUS:
				begin
					nxt_state.rdata[`STAT_SYNCED] = state_ff.synced;
					nxt_state.rdata[`STAT_TX_EN] = state_ff.tx_en;
					nxt_state.rdata[`STAT_EMPTY] = fifo_empty;
					nxt_state.rdata[`STAT_FULL] = fifo_full;
					nxt_state.rdata[`STAT_DROP_LSB+:8] = state_ff.drop_cnt;
					nxt_state.rdata[`STAT_PASS_LSB+:8] = state_ff.pass_cnt;
				end
				`REG_RXDATA:
				begin
					nxt_state.rdata[`RXD_LAST:0] = fifo_out_data;
					nxt_state.rdata[`RXD_VALID] = fifo_out_valid;
				end
				default: nxt_state.rdata = 32'h0000_0000;
			endcase
		end
		else if (bus_req)
		begin
			nxt_state.resp = 1'b0;
			if (avs_write)
			begin
				unique case (avs_address)
					`REG_CTRL:
					begin
						if (avs_byteenable[0])
						begin
							nxt_state.ack_en = avs_writedata[`CTRL_ACK_EN];
						end
					end
					`REG_SOURCE: nxt_state.src = be16(state_ff.src, avs_writedata,
						avs_byteenable);
					`REG_MASK: nxt_state.mask = be16(state_ff.mask, avs_writedata,
						avs_byteenable);
					`REG_DEST: nxt_state.dest = be16(state_ff.dest, avs_writedata,
						avs_byteenable);
					`REG_HOP:
					begin
						if (avs_byteenable[0])
						begin
							nxt_state.hop = avs_writedata[HOP_W-1:0];
						end
					end
					`REG_VENDOR: nxt_state.vendor = VENDOR_W'(be16(16'(state_ff.vendor),
						avs_writedata, avs_byteenable));
					`REG_TXCMD:
					begin
						// Send is refused until the cold start window ends
						if (avs_byteenable[0] && avs_writedata[`TXCMD_SEND] && state_ff.tx_en)
						begin
							nxt_state.tx_valid = 1'b1;
							nxt_state.tx_dest = state_ff.dest;
							// Global when the destination covers our whole mask
							nxt_state.tx_global = masked_eq(state_ff.dest, state_ff.mask,
								state_ff.mask);
							nxt_state.tx_ack_req = state_ff.ack_en && !nxt_state.tx_global;
						end
					end
					default:
					begin
						// Read-only and unmapped words ignore writes
					end
				endcase
			end
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff <= '0;
			state_ff.src <= `RST_SOURCE;
			state_ff.mask <= `RST_MASK;
			state_ff.dest <= `RST_DEST;
		end
		else if (ce)
		begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------------------------------
	// Payload buffer toward the host
	// ----------------------------------------------------------------
	rx_byte_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.in_valid(fifo_push),
		.in_ready(fifo_in_ready),
		.in_data({rx_data_last, rx_data}),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data),
		.level(fifo_level)
	);

	// Outputs
	assign avs_readdata = state_ff.rdata;
	assign ack_send = state_ff.ack_send;
	assign tx_hdr_valid = state_ff.tx_valid;
	assign tx_hdr_hop = state_ff.hop;
	assign tx_hdr_vendor = state_ff.vendor;
	assign tx_hdr_dest = state_ff.tx_dest;
	assign tx_hdr_global = state_ff.tx_global;
	assign tx_hdr_ack_req = state_ff.tx_ack_req;
	assign synced = state_ff.synced;
	assign tx_enabled = state_ff.tx_en;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_hop_drop;
		@(posedge clk_sys) disable iff (!rst_n)
		hdr_take && !hop_ok |=> state_ff.rx_state == RX_DROP;
	endproperty
	a_hop_drop: assert property (p_hop_drop) else $error("wrong channel kept");

	property p_vendor_drop;
		@(posedge clk_sys) disable iff (!rst_n)
		hdr_take && !vendor_ok |=> state_ff.rx_state == RX_DROP && $changed(state_ff.drop_cnt);
	endproperty
	a_vendor_drop: assert property (p_vendor_drop) else $error("wrong vendor kept");

	property p_global_pass;
		@(posedge clk_sys) disable iff (!rst_n)
		hdr_take && hop_ok && vendor_ok && rx_hdr_dest == `ADDR_GLOBAL
		|=> state_ff.rx_state == RX_PASS && state_ff.rx_global;
	endproperty
	a_global_pass: assert property (p_global_pass) else $error("global packet lost");

	property p_no_global_ack;
		@(posedge clk_sys) disable iff (!rst_n)
		ack_send |-> !state_ff.rx_global && $past(rx_hdr_ack_req);
	endproperty
	a_no_global_ack: assert property (p_no_global_ack) else $error("ack for global");

	property p_tx_class;
		@(posedge clk_sys) disable iff (!rst_n)
		tx_hdr_valid |-> tx_hdr_global == ((tx_hdr_dest & state_ff.mask) == state_ff.mask)
		&& !(tx_hdr_global && tx_hdr_ack_req);
	endproperty
	a_tx_class: assert property (p_tx_class) else $error("sent class wrong");

	property p_local_pass;
		@(posedge clk_sys) disable iff (!rst_n)
		hdr_take && hop_ok && vendor_ok && !hdr_global
		&& ((rx_hdr_dest & state_ff.mask) == (state_ff.src & state_ff.mask))
		|=> state_ff.rx_state == RX_PASS;
	endproperty
	a_local_pass: assert property (p_local_pass) else $error("local match lost");

	property p_mask_drop;
		@(posedge clk_sys) disable iff (!rst_n)
		hdr_take && !hdr_global
		&& ((rx_hdr_dest & state_ff.mask) != (state_ff.src & state_ff.mask))
		|=> state_ff.rx_state == RX_DROP;
	endproperty
	a_mask_drop: assert property (p_mask_drop) else $error("mismatch kept");

	property p_sync_window;
		@(posedge clk_sys) disable iff (!rst_n)
		ce && state_ff.boot_cnt >= SYNC_CYCLES |=> synced;
	endproperty
	a_sync_window: assert property (p_sync_window) else $error("sync late");

	property p_cold_tx;
		@(posedge clk_sys) disable iff (!rst_n)
		tx_hdr_valid |-> tx_enabled && state_ff.boot_cnt >= COLD_CYCLES;
	endproperty
	a_cold_tx: assert property (p_cold_tx) else $error("sent before cold start");

	// Outside an admitted packet the buffer level may only fall
	property p_drop_no_push;
		@(posedge clk_sys) disable iff (!rst_n)
		state_ff.rx_state != RX_PASS && ce |=> fifo_level <= $past(fifo_level);
	endproperty
	a_drop_no_push: assert property (p_drop_no_push) else $error("dropped data buffered");

endmodule

// ### rf_filter_defs.svh
/*
 Shared constants of the packet address filter: register word indices, field
 positions, reset values, widths and the cold start and sync timing.
 Assumes a 10 MHz system clock; cycle counts are derived from it.
*/
// Function
// - Check channel, vendor, destination; else discard
// - Sender marks packet global by own mask
// - Destination all ones means global packet
// - Never acknowledge a global packet
// - Accept only packets addressed to us
// - AND packet destination with our mask
// - Sync by 35 ms, transmit by 50 ms
// - Matching data to buffer, others dropped
`ifndef RF_FILTER_DEFS_SVH
`define RF_FILTER_DEFS_SVH

// ----------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------
`define REG_CTRL 4'h0
`define REG_SOURCE 4'h1
`define REG_MASK 4'h2
`define REG_DEST 4'h3
`define REG_HOP 4'h4
`define REG_VENDOR 4'h5
`define REG_TXCMD 4'h6
`define REG_STATUS 4'h7
`define REG_RXDATA 4'h8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_ACK_EN 0
`define TXCMD_SEND 0
`define STAT_SYNCED 0
`define STAT_TX_EN 1
`define STAT_EMPTY 2
`define STAT_FULL 3
`define STAT_DROP_LSB 8
`define STAT_PASS_LSB 16
`define RXD_LAST 8
`define RXD_VALID 9

// ----------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------
`define ADDR_GLOBAL 16'hffff
`define RST_SOURCE 16'h0000
`define RST_MASK 16'hffff
`define RST_DEST 16'hffff
`define HOP_W 8
`define VENDOR_W 16
`define FIFO_DEPTH 4
`define BOOT_CNT_W 20

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ 10000000
`define SYNC_TIME_MS 35
`define COLD_TIME_MS 50
`define SYNC_CYCLES ((`SYNC_TIME_MS * `CLK_HZ) / 1000)
`define COLD_CYCLES ((`COLD_TIME_MS * `CLK_HZ) / 1000)

`endif

// ### rf_filter_pkg.sv
/*
 Types of the packet address filter.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package rf_filter_pkg;

	// Receive packet state, Gray coded from idle
	typedef enum logic [1:0]
	{
		RX_IDLE = 2'b00,
		RX_PASS = 2'b01,
		RX_DROP = 2'b10
	} rx_state_e;

endpackage

// ### rx_byte_fifo.sv
/*
 Small synchronous FIFO with valid and ready on both sides.
 Assumes DEPTH is a power of two and one clock with enable.
*/
module rx_byte_fifo
	import rf_filter_pkg::*;
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] level
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

	typedef struct packed
	{
		logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage words
		logic [AW-1:0] wr; // Write pointer
		logic [AW-1:0] rd; // Read pointer
		logic [CW-1:0] cnt; // Words held
	} fifo_state_s;

	fifo_state_s state_ff;
	fifo_state_s nxt_state;
	logic push; // Word accepted
	logic pop; // Word released

	// Honest flags straight from the count
	assign in_ready = ce && (state_ff.cnt != FULL_CNT);
	assign out_valid = (state_ff.cnt != '0);
	assign out_data = state_ff.mem[state_ff.rd];
	assign level = state_ff.cnt;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready && ce;

	// Next state
	always_comb
	begin
		nxt_state = state_ff;
		if (push)
		begin
			nxt_state.mem[state_ff.wr] = in_data;
			nxt_state.wr = state_ff.wr + 1'b1;
		end
		if (pop)
		begin
			nxt_state.rd = state_ff.rd + 1'b1;
		end
		// Count moves only when one side acts alone
		if (push && !pop)
		begin
			nxt_state.cnt = state_ff.cnt + 1'b1;
		end
		else if (pop && !push)
		begin
			nxt_state.cnt = state_ff.cnt - 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff <= '0;
		end
		else if (ce)
		begin
			state_ff <= nxt_state;
		end
	end

	property p_no_overflow;
		@(posedge clk_sys) disable iff (!rst_n)
		state_ff.cnt <= FULL_CNT;
	endproperty
	a_no_overflow: assert property (p_no_overflow) else $error("fifo count above depth");

endmodule

// ### remote_radio_model.sv
/*
 Remote radio that sends packet headers and payload bytes to the filter.
 Assumes the filter's ready outputs are sampled at rising clk_sys edges.
*/
module remote_radio_model
	import rf_filter_pkg::*;
(
	input wire logic clk_sys,
	input wire logic hdr_ready,
	output logic hdr_valid,
	output logic [7:0] hop,
	output logic [15:0] vendor,
	output logic [15:0] dest,
	output logic glob,
	output logic ack_req,
	input wire logic data_ready,
	output logic data_valid,
	output logic [7:0] data,
	output logic last
);
	// --------------------------------------------------------
	// Idle lines start low; released lines show the inverse
	// --------------------------------------------------------
	initial
	begin
		{hdr_valid, hop, vendor, dest, glob, ack_req} = '0;
		{data_valid, data, last} = '0;
	end

	// Header, then n bytes counting up from b0, last one marked
	task automatic send_pkt(input logic [7:0] h, input logic [15:0] v,
		input logic [15:0] d, input logic g, input logic a, input int n,
		input logic [7:0] b0);
		@(posedge clk_sys);
		hdr_valid <= 1'b1;
		{hop, vendor, dest, glob, ack_req} <= {h, v, d, g, a};
		do @(posedge clk_sys); while (hdr_ready !== 1'b1);
		hdr_valid <= 1'b0;
		{hop, vendor, dest, glob, ack_req} <= ~{h, v, d, g, a};
		for (int i = 0; i < n; i++)
		begin
			data_valid <= 1'b1;
			data <= b0 + 8'(i);
			last <= (i == n - 1);
			do @(posedge clk_sys); while (data_ready !== 1'b1);
		end
		data_valid <= 1'b0;
		data <= ~(b0 + 8'(n - 1));
		last <= 1'b0;
	endtask
endmodule

// ### rf_packet_address_filter_tb.sv
/*
 Self-checking bench of the packet address filter.
 Assumes short sync and cold start counts of 20 and 30 cycles.
*/
`include "rf_filter_defs.svh"
module rf_packet_address_filter_tb
	import rf_filter_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, rst_n, ce, avs_read, avs_write, avs_waitrequest;
	logic [3:0] avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, d;
	logic rx_hdr_valid, rx_hdr_ready, rx_hdr_global, rx_hdr_ack_req;
	logic [7:0] rx_hdr_hop, rx_data;
	logic [15:0] rx_hdr_vendor, rx_hdr_dest, tx_hdr_vendor, tx_hdr_dest;
	logic rx_data_valid, rx_data_ready, rx_data_last, ack_send;
	logic tx_hdr_valid, tx_hdr_global, tx_hdr_ack_req, synced, tx_enabled;
	logic [7:0] tx_hdr_hop;
	int mismatches, num_checks, cyc, acks, txp, a0;
	// Packet table: hop, vendor, dest, global flag, pass, ack
	logic [7:0] ph[6] = '{8'h05, 8'h06, 8'h05, 8'h05, 8'h05, 8'h05};
	logic [15:0] pv[6] = '{16'h1234, 16'h1234, 16'h4321, 16'h1234, 16'h1234, 16'h1234};
	logic [15:0] pd[6] = '{16'h1142, 16'h0042, 16'h0042, 16'h0043, 16'hffff, 16'h0000};
	logic pg[6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
	logic pp[6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
	int pa[6] = '{1, 0, 0, 0, 0, 0};
	// Sender table: mask, dest, expected global flag
	logic [15:0] tm[4] = '{16'hffff, 16'h00ff, 16'h00ff, 16'h0000};
	logic [15:0] td[4] = '{16'hffff, 16'h12ff, 16'h1234, 16'h1234};
	logic tg[4] = '{1'b1, 1'b1, 1'b0, 1'b1};

	rf_packet_address_filter #(.SYNC_CYCLES(20'd20), .COLD_CYCLES(20'd30)) dut_u (.*);

	remote_radio_model radio_u (.clk_sys(clk_sys), .hdr_ready(rx_hdr_ready),
		.hdr_valid(rx_hdr_valid), .hop(rx_hdr_hop), .vendor(rx_hdr_vendor),
		.dest(rx_hdr_dest), .glob(rx_hdr_global), .ack_req(rx_hdr_ack_req),
		.data_ready(rx_data_ready), .data_valid(rx_data_valid), .data(rx_data),
		.last(rx_data_last));

	// --------------------------------------------------------
	// Clock, pulse counters and hang guard
	// --------------------------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys)
	begin
		cyc++;
		if (ack_send === 1'b1) acks++;
		if (tx_hdr_valid === 1'b1) txp++;
		if (cyc == 3000)
		begin
			mismatches++;
			stop_test();
		end
	end

	// Bus read and write: hold until waitrequest low at an edge
	task automatic bus_rd(input logic [3:0] a, output logic [31:0] q);
		@(posedge clk_sys);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
	endtask

	task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= v;
		avs_write <= 1'b1;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask

	// Compare one value, report and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// --------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------
	initial
	begin
		{rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
		{mismatches, num_checks, cyc, acks, txp} = '0;
		ce = 1'b1;
		avs_byteenable = 4'hf;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		// Reset values, unmapped place, early status
		bus_rd(`REG_STATUS, d); chk(d, 32'h4);
		bus_rd(`REG_MASK, d); chk(d, 32'hffff);
		bus_rd(`REG_DEST, d); chk(d, 32'hffff);
		bus_wr(4'h9, 32'h55);
		bus_rd(4'h9, d); chk(d, 32'h0);
		bus_wr(`REG_TXCMD, 32'h1);
		repeat (3) @(posedge clk_sys);
		chk(txp, 0);
		repeat (30) @(posedge clk_sys);
		chk({synced, tx_enabled}, 2'b11);
		// Sender marks packets global or local
		bus_wr(`REG_CTRL, 32'h1);
		for (int k = 0; k < 4; k++)
		begin
			bus_wr(`REG_MASK, tm[k]);
			bus_wr(`REG_DEST, td[k]);
			bus_wr(`REG_TXCMD, 32'h1);
			repeat (2) @(posedge clk_sys);
			chk({tx_hdr_global, tx_hdr_ack_req, tx_hdr_dest}, {tg[k], ~tg[k], td[k]});
		end
		chk(txp, 4);
		// Receiver filtering, forwarding and acks
		bus_wr(`REG_HOP, 32'h5);
		bus_wr(`REG_VENDOR, 32'h1234);
		bus_wr(`REG_SOURCE, 32'h0042);
		bus_wr(`REG_MASK, 32'h00ff);
		bus_rd(`REG_SOURCE, d); chk(d, 32'h0042);
		chk({tx_hdr_hop, tx_hdr_vendor}, {8'h05, 16'h1234});
		for (int k = 0; k < 6; k++)
		begin
			a0 = acks;
			radio_u.send_pkt(ph[k], pv[k], pd[k], pg[k], 1'b1, 2, {4'(k), 4'h0});
			repeat (2) @(posedge clk_sys);
			chk(acks - a0, pa[k]);
			if (pp[k])
			begin
				bus_rd(`REG_RXDATA, d); chk(d, {22'h0, 2'b10, 4'(k), 4'h0});
				bus_rd(`REG_RXDATA, d); chk(d, {22'h0, 2'b11, 4'(k), 4'h1});
			end
		end
		bus_rd(`REG_STATUS, d); chk(d, 32'h00030307);
		bus_rd(`REG_RXDATA, d); chk(d & 32'h200, 32'h0);
		// Buffer fills while the host holds off, then drains
		fork
			radio_u.send_pkt(8'h05, 16'h1234, 16'hff42, 1'b0, 1'b0, 6, 8'ha0);
			begin
				repeat (14) @(posedge clk_sys);
				bus_rd(`REG_STATUS, d); chk(d, 32'h0004030b);
				for (int i = 0; i < 6; i++)
				begin
					bus_rd(`REG_RXDATA, d);
					chk(d, {22'h0, 1'b1, i == 5, 8'ha0 + 8'(i)});
				end
			end
		join
		// Local packet asking for an ack while acks are disabled
		bus_wr(`REG_CTRL, 32'h0);
		bus_rd(`REG_CTRL, d); chk(d, 32'h0);
		a0 = acks;
		radio_u.send_pkt(8'h05, 16'h1234, 16'h0042, 1'b0, 1'b1, 1, 8'hc0);
		repeat (2) @(posedge clk_sys);
		chk(acks - a0, 0);
		bus_rd(`REG_RXDATA, d); chk(d, 32'h000003c0);
		bus_rd(`REG_STATUS, d); chk(d, 32'h00050307);
		stop_test();
	end
endmodule
